// ### src/ubfp_pkg.sv
// Shared constants and types for the USB byte FIFO parallel port
package ubfp_pkg;
   localparam int DATA_W = 8;
   localparam int RX_DEPTH = 256;
   localparam int TX_DEPTH = 128;
   localparam int CLK_HZ = 40_000_000;
   localparam int MS_PER_S = 1000;
   localparam int CYCLES_PER_MS = CLK_HZ / MS_PER_S;
   localparam logic [7:0] TX_TIMEOUT_DEFAULT_MS = 8'h10;
   localparam logic [7:0] TX_TIMEOUT_MIN_MS = 8'h01;
   localparam logic [7:0] TX_TIMEOUT_MAX_MS = 8'hFF;
   localparam logic [1:0] SYNC_RESET = 2'h3;
   typedef enum logic {
      UBFP_TX_GATHER,
      UBFP_TX_FLUSH
   } ubfp_tx_state_t;
endpackage

// ### src/ubfp_fifo_if.sv
// Interface between the port logic and one byte buffer
`timescale 1ns/10ps
interface ubfp_fifo_if #(
   parameter int W = 8,
   parameter int DEPTH = 256
);
   localparam int LW = $clog2(DEPTH + 1);
   logic push;
   logic [W-1:0] push_data;
   logic pop;
   logic [W-1:0] head;
   logic [LW-1:0] level;
   logic full;
   logic empty;
   modport user (output push, output push_data, output pop,
      input head, input level, input full, input empty);
   modport store (input push, input push_data, input pop,
      output head, output level, output full, output empty);
endinterface

// ### src/ubfp_fifo.sv
// Byte buffer held in flip-flops with read and write indices
`timescale 1ns/10ps
module ubfp_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 256
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   ubfp_fifo_if.store f
);
   import ubfp_pkg::*;
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int LW = $clog2(DEPTH + 1);
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
   localparam logic [LW-1:0] FULL_LVL = LW'(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0] wptr;
      logic [AW-1:0] rptr;
      logic [LW-1:0] level;
   } ubfp_fifo_state_t;

   ubfp_fifo_state_t s_q;
   ubfp_fifo_state_t s_d;
   logic do_push;
   logic do_pop;

   assign do_push = f.push && (s_q.level != FULL_LVL);
   assign do_pop = f.pop && (s_q.level != '0);
   assign f.head = s_q.mem[s_q.rptr];
   assign f.level = s_q.level;
   assign f.full = (s_q.level == FULL_LVL);
   assign f.empty = (s_q.level == '0);

   always_comb begin
      s_d = s_q;
      if (do_push) begin
         s_d.mem[s_q.wptr] = f.push_data;
         s_d.wptr = (s_q.wptr == LAST) ? '0 : s_q.wptr + 1'b1;
      end
      if (do_pop) begin
         s_d.rptr = (s_q.rptr == LAST) ? '0 : s_q.rptr + 1'b1;
      end
      s_d.level = s_q.level + LW'(do_push) - LW'(do_pop);
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule

// ### src/ubfp_top.sv
// Parallel byte FIFO port: strobe-paced pins, receive and transmit buffers
//
// Notes on behaviour
// R1: Power indicator low when configured, high suspended
// R2: Read strobe low drives head byte out
// R3: Read strobe rising releases bus, advances buffer
// R4: Write strobe falling appends sampled byte
// R5: Forward transmit bytes within flush timeout
// R6: Flush timeout programmable 1 to 255 ms
// R7: Partner never writes while room flag high
// R8: Partner writes by strobing high then low
// R9: Both flags undriven throughout reset
// R10: Receive flag high when buffer empty
// R11: Wakeup option: receive flag becomes input suspended
// R12: Receive flag low when bytes waiting
// R13: Partner reads only while receive flag low
`timescale 1ns/10ps
module ubfp_top #(
   parameter int MS_CYCLES = ubfp_pkg::CYCLES_PER_MS,
   parameter int RX_DEPTH = ubfp_pkg::RX_DEPTH,
   parameter int TX_DEPTH = ubfp_pkg::TX_DEPTH
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic read_strobe_n,
   input wire logic write_strobe,
   input wire logic [ubfp_pkg::DATA_W-1:0] fifo_bus_in,
   output logic [ubfp_pkg::DATA_W-1:0] fifo_bus_out,
   output logic fifo_bus_oe,
   output logic receive_avail_n,
   output logic receive_avail_oe,
   input wire logic receive_avail_in,
   output logic transmit_room_n,
   output logic transmit_room_oe,
   output logic power_on_indicator_n,
   output logic remote_wake_req,
   input wire logic usb_configured,
   input wire logic usb_suspend,
   input wire logic remote_wakeup_en,
   input wire logic [7:0] tx_timeout_ms,
   input wire logic usb_rx_valid,
   input wire logic [ubfp_pkg::DATA_W-1:0] usb_rx_data,
   output logic usb_rx_ready,
   output logic usb_tx_valid,
   output logic [ubfp_pkg::DATA_W-1:0] usb_tx_data,
   input wire logic usb_tx_ready
);
   import ubfp_pkg::*;

   localparam int RLW = $clog2(RX_DEPTH + 1);
   localparam int TLW = $clog2(TX_DEPTH + 1);
   localparam logic [RLW-1:0] RX_FULL_LVL = RLW'(RX_DEPTH);
   localparam logic [TLW-1:0] TX_FULL_LVL = TLW'(TX_DEPTH);
   localparam logic [31:0] MS_LAST = 32'(MS_CYCLES - 1);

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      logic [1:0] rd_s;
      logic rd_prev;
      logic [1:0] wr_s;
      logic wr_prev;
      logic [1:0][DATA_W-1:0] bus_s;
      logic [1:0] wake_s;
      logic [DATA_W-1:0] drv_data;
      logic drv_oe;
      logic avail_n;
      logic avail_oe;
      logic room_n;
      logic room_oe;
      logic pwr_n;
      logic wake;
      ubfp_tx_state_t tx_st;
      logic [31:0] cyc;
      logic [7:0] ms;
      logic tx_valid;
      logic [DATA_W-1:0] tx_data;
      logic rx_ready;
   } ubfp_state_t;

   ubfp_state_t s_q;
   ubfp_state_t s_d;

   ubfp_fifo_if #(.W(DATA_W), .DEPTH(RX_DEPTH)) rxf ();
   ubfp_fifo_if #(.W(DATA_W), .DEPTH(TX_DEPTH)) txf ();

   ubfp_fifo #(.W(DATA_W), .DEPTH(RX_DEPTH)) u_rx_fifo (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .f(rxf.store)
   );

   ubfp_fifo #(.W(DATA_W), .DEPTH(TX_DEPTH)) u_tx_fifo (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .f(txf.store)
   );

   // ****************************************************************
   // Strobe edges and buffer traffic
   // ****************************************************************
   logic rd_rise;
   logic wr_fall;
   logic tx_pop;
   logic [7:0] tmo;
   logic [RLW-1:0] rx_next;
   logic [TLW-1:0] tx_next;

   assign rd_rise = s_q.rd_s[1] && !s_q.rd_prev;
   // Writes arriving while full are dropped; the room flag warns the partner
   assign wr_fall = !s_q.wr_s[1] && s_q.wr_prev; // R4 R7 R8
   assign tmo = (tx_timeout_ms < TX_TIMEOUT_MIN_MS) ? TX_TIMEOUT_DEFAULT_MS : tx_timeout_ms; // R6
   assign tx_pop = (s_q.tx_st == UBFP_TX_FLUSH) && !txf.empty
      && (!s_q.tx_valid || usb_tx_ready); // R5

   assign rxf.push = usb_rx_valid && s_q.rx_ready;
   assign rxf.push_data = usb_rx_data;
   assign rxf.pop = rd_rise && !rxf.empty; // R3 R13
   assign txf.push = wr_fall && !txf.full; // R4
   assign txf.push_data = s_q.bus_s[1];
   assign txf.pop = tx_pop;

   assign rx_next = rxf.level + RLW'(rxf.push) - RLW'(rxf.pop);
   assign tx_next = txf.level + TLW'(txf.push) - TLW'(txf.pop);

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      s_d = s_q;
      // Stage one of each synchroniser feeds only stage two
      s_d.rd_s = {s_q.rd_s[0], read_strobe_n};
      s_d.rd_prev = s_q.rd_s[1];
      s_d.wr_s = {s_q.wr_s[0], write_strobe};
      s_d.wr_prev = s_q.wr_s[1];
      s_d.bus_s = {s_q.bus_s[0], fifo_bus_in};
      s_d.wake_s = {s_q.wake_s[0], receive_avail_in};

      // Head byte is shown for the whole low phase of the read strobe
      s_d.drv_oe = !s_q.rd_s[1]; // R2 R3
      s_d.drv_data = rxf.head; // R2

      s_d.pwr_n = !(usb_configured && !usb_suspend); // R1
      s_d.avail_n = (rx_next == '0); // R10 R12
      s_d.avail_oe = !(remote_wakeup_en && usb_suspend && s_q.pwr_n); // R11
      s_d.wake = !s_d.avail_oe && !s_q.wake_s[1]; // R11
      s_d.room_n = (tx_next == TX_FULL_LVL); // R7
      s_d.room_oe = 1'b1;
      s_d.rx_ready = (rx_next != RX_FULL_LVL);

      if (tx_pop) begin
         s_d.tx_valid = 1'b1;
         s_d.tx_data = txf.head;
      end else if (usb_tx_ready) begin
         s_d.tx_valid = 1'b0;
      end

      unique case (s_q.tx_st)
         UBFP_TX_GATHER: begin
            if (txf.empty) begin
               s_d.cyc = '0;
               s_d.ms = '0;
            end else if (txf.full || s_q.ms >= tmo) begin
               s_d.tx_st = UBFP_TX_FLUSH; // R5
            end else if (s_q.cyc == MS_LAST) begin
               s_d.cyc = '0;
               s_d.ms = (s_q.ms == TX_TIMEOUT_MAX_MS) ? s_q.ms : s_q.ms + 8'h01; // R6
            end else begin
               s_d.cyc = s_q.cyc + 32'h1;
            end
         end
         UBFP_TX_FLUSH: begin
            // Drain everything once started; bytes written meanwhile ride along
            if (txf.empty) begin
               s_d.tx_st = UBFP_TX_GATHER;
               s_d.cyc = '0;
               s_d.ms = '0;
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         s_q <= '0;
         s_q.rd_s <= SYNC_RESET;
         s_q.rd_prev <= 1'b1;
         // Flag pin idles high; a low reset value would fake a wake request
         s_q.wake_s <= SYNC_RESET;
         s_q.pwr_n <= 1'b1;
         s_q.avail_n <= 1'b1;
         s_q.room_n <= 1'b1;
         s_q.tx_st <= UBFP_TX_GATHER;
         s_q.avail_oe <= 1'b0; // R9
         s_q.room_oe <= 1'b0; // R9
      end else begin
         s_q <= s_d;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign fifo_bus_out = s_q.drv_data;
   assign fifo_bus_oe = s_q.drv_oe;
   assign receive_avail_n = s_q.avail_n;
   assign receive_avail_oe = s_q.avail_oe;
   assign transmit_room_n = s_q.room_n;
   assign transmit_room_oe = s_q.room_oe;
   assign power_on_indicator_n = s_q.pwr_n;
   assign remote_wake_req = s_q.wake;
   assign usb_rx_ready = s_q.rx_ready;
   assign usb_tx_valid = s_q.tx_valid;
   assign usb_tx_data = s_q.tx_data;
endmodule

// ### test/ubfp_top_sva.sv
// Pin-level checks of the parallel FIFO port
`timescale 1ns/10ps
module ubfp_top_sva (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic read_strobe_n,
   input wire logic [7:0] fifo_bus_out,
   input wire logic fifo_bus_oe,
   input wire logic receive_avail_n,
   input wire logic receive_avail_oe,
   input wire logic transmit_room_oe,
   input wire logic power_on_indicator_n,
   input wire logic usb_configured,
   input wire logic usb_suspend,
   input wire logic remote_wakeup_en,
   input wire logic usb_rx_valid,
   input wire logic usb_rx_ready,
   input wire logic usb_tx_valid,
   input wire logic [7:0] usb_tx_data,
   input wire logic usb_tx_ready
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   a_reset_undriven: assert property (disable iff (1'b0)
      !rst_b |=> !transmit_room_oe && !receive_avail_oe) else $error("flag driven in reset");
   a_room_driven: assert property ($past(rst_b) |-> transmit_room_oe)
      else $error("room flag undriven");
   a_power_on: assert property (usb_configured && !usb_suspend |=> !power_on_indicator_n)
      else $error("power indicator not low");
   a_power_off: assert property (usb_suspend |=> power_on_indicator_n)
      else $error("power indicator not high");
   a_bus_drive: assert property (!read_strobe_n [*3] |=> fifo_bus_oe)
      else $error("bus not driven");
   a_bus_release: assert property (read_strobe_n [*3] |=> !fifo_bus_oe)
      else $error("bus not released");
   a_bus_steady: assert property (fifo_bus_oe && $past(fifo_bus_oe) |-> $stable(fifo_bus_out))
      else $error("bus byte moved");
   a_avail_fills: assert property (usb_rx_valid && usb_rx_ready |-> ##[1:3] !receive_avail_n)
      else $error("avail flag stuck high");
   a_tx_hold: assert property (usb_tx_valid && !usb_tx_ready |=> usb_tx_valid && $stable(usb_tx_data))
      else $error("tx byte dropped");
   a_wake_input: assert property (remote_wakeup_en && usb_suspend && power_on_indicator_n
      |=> !receive_avail_oe) else $error("avail pin still driven");
endmodule
bind ubfp_top ubfp_top_sva chk_u (
   .ref_clk(ref_clk),
   .rst_b(rst_b),
   .read_strobe_n(read_strobe_n),
   .fifo_bus_out(fifo_bus_out),
   .fifo_bus_oe(fifo_bus_oe),
   .receive_avail_n(receive_avail_n),
   .receive_avail_oe(receive_avail_oe),
   .transmit_room_oe(transmit_room_oe),
   .power_on_indicator_n(power_on_indicator_n),
   .usb_configured(usb_configured),
   .usb_suspend(usb_suspend),
   .remote_wakeup_en(remote_wakeup_en),
   .usb_rx_valid(usb_rx_valid),
   .usb_rx_ready(usb_rx_ready),
   .usb_tx_valid(usb_tx_valid),
   .usb_tx_data(usb_tx_data),
   .usb_tx_ready(usb_tx_ready)
);

// ### test/ubfp_host_model.sv
// External logic that strobes bytes through the port
`timescale 1ns/10ps
module ubfp_host_model (
   input wire logic ref_clk,
   input wire logic [7:0] fifo_bus_out,
   input wire logic fifo_bus_oe,
   input wire logic transmit_room_n,
   input wire logic receive_avail_n,
   output logic read_strobe_n,
   output logic write_strobe,
   output logic [7:0] fifo_bus_in
);
   logic [7:0] drv_q = 8'h00;
   // Shared wire: the port wins while it drives
   assign fifo_bus_in = fifo_bus_oe ? fifo_bus_out : drv_q;
   initial begin
      read_strobe_n = 1'b1;
      write_strobe = 1'b0;
   end
   task automatic wr_byte(input logic [7:0] d);
      @(posedge ref_clk);
      while (transmit_room_n !== 1'b0) @(posedge ref_clk);
      drv_q <= d;
      write_strobe <= 1'b1;
      repeat (4) @(posedge ref_clk);
      write_strobe <= 1'b0;
      repeat (4) @(posedge ref_clk);
      drv_q <= ~d; // Released: never leave a stale byte looking valid
   endtask
   task automatic rd_byte(input int hold, output logic [7:0] d);
      @(posedge ref_clk);
      while (receive_avail_n !== 1'b0) @(posedge ref_clk);
      read_strobe_n <= 1'b0;
      repeat (hold) @(posedge ref_clk);
      @(negedge ref_clk);
      d = fifo_bus_oe ? fifo_bus_in : 8'hXX;
      @(posedge ref_clk);
      read_strobe_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
   endtask
endmodule

// ### test/ubfp_top_bench.sv
// Self-checking bench for the parallel FIFO port
`timescale 1ns/10ps
module ubfp_top_bench;
   localparam int MS = 10;
   logic ref_clk, rst_b, read_strobe_n, write_strobe, fifo_bus_oe, receive_avail_n;
   logic receive_avail_oe, transmit_room_n, transmit_room_oe, power_on_indicator_n;
   logic remote_wake_req, usb_rx_ready, usb_tx_valid;
   logic [7:0] fifo_bus_in, fifo_bus_out, usb_tx_data;
   logic receive_avail_in = 1'b1;
   logic usb_configured = 1'b0, usb_suspend = 1'b0, remote_wakeup_en = 1'b0;
   logic usb_rx_valid = 1'b0, usb_tx_ready = 1'b0;
   logic [7:0] usb_rx_data = 8'h00, tx_timeout_ms = 8'h10;
   logic [7:0] tmo [4] = '{8'h01, 8'h03, 8'h00, 8'hFF};
   int fails = 0, n_tests = 0, cyc = 0;
   // Small depths and a short ms keep full and timeout cases cheap
   ubfp_top #(.MS_CYCLES(MS), .RX_DEPTH(4), .TX_DEPTH(4)) dut_u (.ref_clk, .rst_b,
      .read_strobe_n, .write_strobe, .fifo_bus_in, .fifo_bus_out, .fifo_bus_oe,
      .receive_avail_n, .receive_avail_oe, .receive_avail_in, .transmit_room_n,
      .transmit_room_oe, .power_on_indicator_n, .remote_wake_req, .usb_configured,
      .usb_suspend, .remote_wakeup_en, .tx_timeout_ms, .usb_rx_valid, .usb_rx_data,
      .usb_rx_ready, .usb_tx_valid, .usb_tx_data, .usb_tx_ready);
   ubfp_host_model host_u (.ref_clk, .fifo_bus_out, .fifo_bus_oe, .transmit_room_n,
      .receive_avail_n, .read_strobe_n, .write_strobe, .fifo_bus_in);
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   task automatic end_of_test();
      if (fails == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         end_of_test();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic push_rx(input logic [7:0] d);
      @(posedge ref_clk);
      usb_rx_valid <= 1'b1;
      usb_rx_data <= d;
      do @(posedge ref_clk); while (usb_rx_ready !== 1'b1);
      usb_rx_valid <= 1'b0;
   endtask
   task automatic pop_tx(input logic [7:0] exp, input int maxw);
      int n = 0;
      @(posedge ref_clk);
      while (usb_tx_valid !== 1'b1 && n < maxw) begin
         @(posedge ref_clk);
         n++;
      end
      chk({7'h00, usb_tx_valid}, 8'h01);
      chk(usb_tx_data, exp);
      usb_tx_ready <= 1'b1;
      @(posedge ref_clk);
      usb_tx_ready <= 1'b0;
   endtask
   task automatic t_power();
      usb_configured <= 1'b1;
      repeat (3) @(posedge ref_clk);
      chk({7'h00, power_on_indicator_n}, 8'h00);
      usb_suspend <= 1'b1;
      remote_wakeup_en <= 1'b1;
      // Partner pulls the released flag pin low to ask for wakeup
      receive_avail_in <= 1'b0;
      repeat (4) @(posedge ref_clk);
      chk({5'h00, power_on_indicator_n, receive_avail_oe, remote_wake_req}, 8'h05);
      usb_suspend <= 1'b0;
      remote_wakeup_en <= 1'b0;
      receive_avail_in <= 1'b1;
      repeat (3) @(posedge ref_clk);
      chk({5'h00, power_on_indicator_n, receive_avail_oe, remote_wake_req}, 8'h02);
   endtask
   task automatic t_read();
      logic [7:0] d;
      push_rx(8'hA5);
      push_rx(8'h3C);
      push_rx(8'h0F);
      push_rx(8'hF0);
      repeat (3) @(posedge ref_clk);
      // Buffer of four is full: the USB side must be held off
      chk({6'h00, usb_rx_ready, receive_avail_n}, 8'h00);
      host_u.rd_byte(4, d);
      chk(d, 8'hA5);
      host_u.rd_byte(12, d);
      chk(d, 8'h3C);
      host_u.rd_byte(4, d);
      chk(d, 8'h0F);
      host_u.rd_byte(4, d);
      chk(d, 8'hF0);
      chk({6'h00, fifo_bus_oe, receive_avail_n}, 8'h01);
   endtask
   task automatic t_fill();
      tx_timeout_ms <= 8'hFF;
      for (int i = 0; i < 4; i++) host_u.wr_byte(8'h50 + 8'(i));
      // Full only briefly: a full buffer starts draining two cycles later
      @(negedge ref_clk);
      chk({7'h00, transmit_room_n}, 8'h01);
      for (int i = 0; i < 4; i++) pop_tx(8'h50 + 8'(i), 20);
      repeat (3) @(posedge ref_clk);
      chk({7'h00, transmit_room_n}, 8'h00);
   endtask
   task automatic t_timeout(input logic [7:0] ms);
      int lim;
      lim = (ms == 8'h00 ? 16 : int'(ms)) * MS;
      tx_timeout_ms <= ms;
      host_u.wr_byte(ms);
      repeat (lim / 2) @(posedge ref_clk);
      chk({7'h00, usb_tx_valid}, 8'h00);
      pop_tx(ms, lim / 2 + 8);
   endtask
   initial begin
      rst_b = 1'b0;
      repeat (3) @(posedge ref_clk);
      chk({5'h00, transmit_room_oe, receive_avail_oe, fifo_bus_oe}, 8'h00);
      @(posedge ref_clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge ref_clk);
      chk({6'h00, receive_avail_n, transmit_room_n}, 8'h02);
      t_power();
      t_read();
      t_fill();
      foreach (tmo[i]) t_timeout(tmo[i]);
      end_of_test();
   end
endmodule
